// file: core/pwr_ctl.sv
// burst mode and auto-restart control unit with wishbone register access
`timescale 1ns/1ps
// Function
// [R1] fixed 20 ms blanking before burst or auto-restart entry
// [R2] burst-entry counter held at zero while feedback not below entry level
// [R3] burst-entry counter starts once feedback falls below 1.35 V
// [R4] burst entered only when counter reaches 20 ms, feedback still low
// [R5] burst entry sets burst flag and drops bias enable
// [R6] startup cell held off throughout burst mode
// [R7] in burst with bias off, feedback above 3.5 V re-enables bias
// [R8] burst mode selects the reduced 0.34 V current limit
// [R9] in burst while switching, feedback down at 3.0 V drops bias
// [R10] feedback above 4.0 V leaves burst and restores full current
// [R11] burst uses fixed blanking only; restart supports fixed and extended
// [R12] feedback above 4.0 V starts the protection blanking counter
// [R13] protection counter at 20 ms releases the blanking-pin clamp
// [R14] extended blanking ends only when blanking pin reaches 4.0 V
// [R15] further 30 us spike blanking before auto-restart activates
// [R16] blanking delays apply only to overload and open loop
// [R17] supply, thermal, opto and external faults restart without blanking
// [R18] restart: stop, cell on at turn-off, cell off and power at turn-on
// [R19] after startup recheck fault: restart again or resume normal
// [R20] soft start at power-up and every restart attempt
// [R21] soft start completes 20 ms after switching on
// [R22] inputs synchronised; intervals counted on the internal clock
// [R23] running blanking counter cleared when its cause disappears
module pwr_ctl #(
  parameter int unsigned BLANK_CYC = pwr_ctl_pkg::BLANK_CYC,
  parameter int unsigned SOFT_CYC  = pwr_ctl_pkg::SOFT_CYC,
  parameter int unsigned SPIKE_CYC = pwr_ctl_pkg::SPIKE_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // comparators
  input  wire logic        burst_entry_comparator_i,
  input  wire logic        burst_wake_comparator_i,
  input  wire logic        burst_sleep_comparator_i,
  input  wire logic        overload_comparator_i,
  input  wire logic        blanking_pin_comparator_i,
  input  wire logic        vcc_off_cmp_i,
  input  wire logic        vcc_on_cmp_i,
  // fault indications
  input  wire logic        vcc_ovp_i,
  input  wire logic        over_temp_i,
  input  wire logic        vcc_uvlo_i,
  input  wire logic        opto_short_i,
  input  wire logic        ext_restart_i,
  // control outputs
  output logic             burst_flag_o,
  output logic             bias_en_o,
  output logic             reduced_limit_o,
  output logic             clamp_release_o,
  output logic             startup_cell_en_o,
  output logic             auto_restart_o,
  output logic             soft_start_o
);
  // ********************************
  // input synchronisation
  // ********************************
  logic [pwr_ctl_pkg::N_IN-1:0] raw;
  logic [pwr_ctl_pkg::N_IN-1:0] syn;
  logic                         fb_low;
  logic                         fb_wake;
  logic                         fb_sleep;
  logic                         fb_over;
  logic                         ba_high;
  logic                         vcc_off;
  logic                         vcc_on;
  logic                         hard_fault;
  logic [1:0]                   ctrl_q;
  logic [pwr_ctl_pkg::CNT_W-1:0] count_q;
  pwr_ctl_pkg::mode_t           mode_q;

  assign raw = {burst_wake_comparator_i, ext_restart_i, opto_short_i, vcc_uvlo_i,
                over_temp_i, vcc_ovp_i, vcc_on_cmp_i, vcc_off_cmp_i, blanking_pin_comparator_i,
                overload_comparator_i, burst_sleep_comparator_i, burst_entry_comparator_i};

  sync_bank #(.W(pwr_ctl_pkg::N_IN)) u_sync ( // R22
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (raw),
    .sync_o  (syn)
  );

  assign fb_low   = syn[0];
  assign fb_sleep = syn[1];
  assign fb_over  = syn[2];
  assign ba_high  = syn[3];
  assign vcc_off  = syn[4];
  assign vcc_on   = syn[5];
  assign fb_wake  = syn[11];
  // software can raise the external restart request as well
  assign hard_fault = |syn[10:6] | ctrl_q[pwr_ctl_pkg::CTRL_SWF]; // R17

  // ********************************
  // blanking and soft-start timers
  // ********************************
  logic powered;
  logic burst_run;
  logic burst_done;
  logic prot_run;
  logic prot_done;
  logic spike_run;
  logic spike_done;
  logic soft_done;
  logic gate_open;

  assign powered = (mode_q == pwr_ctl_pkg::ST_NORMAL);
  // only the normal state may count towards burst; any rise above 1.35 V clears
  assign burst_run = powered && fb_low; // R2 R3 R23
  interval_timer #(.LIMIT(BLANK_CYC)) u_burst_tmr ( // R1 R4
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (burst_run),
    .done_o (burst_done)
  );

  // overload or open loop is the only cause that runs the blanking chain
  assign prot_run = (powered || mode_q == pwr_ctl_pkg::ST_BURST) && fb_over; // R12 R16 R23
  interval_timer #(.LIMIT(BLANK_CYC)) u_prot_tmr ( // R1 R13
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (prot_run),
    .done_o (prot_done)
  );

  // basic mode skips the pin; extended mode waits for the charged capacitor
  assign gate_open = prot_done &&
                     (ba_high || !ctrl_q[pwr_ctl_pkg::CTRL_EXT]); // R11 R14
  assign spike_run = gate_open; // R23
  interval_timer #(.LIMIT(SPIKE_CYC)) u_spike_tmr ( // R15
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (spike_run),
    .done_o (spike_done)
  );

  interval_timer #(.LIMIT(SOFT_CYC)) u_soft_tmr ( // R21
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (mode_q == pwr_ctl_pkg::ST_SOFT),
    .done_o (soft_done)
  );

  // ********************************
  // mode sequencing
  // ********************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= pwr_ctl_pkg::ST_CHARGE;
    end else begin
      unique case (mode_q)
        pwr_ctl_pkg::ST_CHARGE: begin
          if (vcc_on) begin
            mode_q <= pwr_ctl_pkg::ST_SOFT; // R18 R20
          end
        end
        pwr_ctl_pkg::ST_SOFT: begin
          if (hard_fault) begin
            mode_q <= pwr_ctl_pkg::ST_RESTART; // R17
          end else if (soft_done) begin
            // fault recheck at the end of the startup phase
            mode_q <= fb_over ? pwr_ctl_pkg::ST_RESTART
                              : pwr_ctl_pkg::ST_NORMAL; // R19
          end
        end
        pwr_ctl_pkg::ST_NORMAL: begin
          if (hard_fault || spike_done) begin
            mode_q <= pwr_ctl_pkg::ST_RESTART; // R15 R17
          end else if (burst_done && fb_low) begin
            mode_q <= pwr_ctl_pkg::ST_BURST; // R4
          end
        end
        pwr_ctl_pkg::ST_BURST: begin
          if (hard_fault) begin
            mode_q <= pwr_ctl_pkg::ST_RESTART; // R17
          end else if (fb_over) begin
            mode_q <= pwr_ctl_pkg::ST_NORMAL; // R10
          end
        end
        pwr_ctl_pkg::ST_RESTART: begin
          if (vcc_off) begin
            mode_q <= pwr_ctl_pkg::ST_CHARGE; // R18
          end
        end
      endcase
    end
  end

  // ********************************
  // bias enable
  // ********************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bias_en_o <= 1'b0;
    end else if (mode_q == pwr_ctl_pkg::ST_BURST) begin
      if (fb_over) begin
        bias_en_o <= 1'b1; // R10
      end else if (!bias_en_o && fb_wake) begin
        bias_en_o <= 1'b1; // R7
      end else if (bias_en_o && fb_sleep) begin
        bias_en_o <= 1'b0; // R9
      end
    end else if (mode_q == pwr_ctl_pkg::ST_NORMAL && burst_done && fb_low && !hard_fault
                 && !spike_done) begin
      bias_en_o <= 1'b0; // R5
    end else begin
      bias_en_o <= (mode_q == pwr_ctl_pkg::ST_NORMAL || mode_q == pwr_ctl_pkg::ST_SOFT)
                   && !hard_fault && !spike_done; // R18
    end
  end

  // ********************************
  // derived control outputs
  // ********************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      burst_flag_o    <= 1'b0;
      reduced_limit_o <= 1'b0;
    end else begin
      burst_flag_o    <= (mode_q == pwr_ctl_pkg::ST_BURST) && !fb_over; // R5 R10
      reduced_limit_o <= (mode_q == pwr_ctl_pkg::ST_BURST) && !fb_over; // R8 R10
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      startup_cell_en_o <= 1'b1;
    end else begin
      // cell charges only from turn-off until turn-on; never in burst
      startup_cell_en_o <= (mode_q == pwr_ctl_pkg::ST_CHARGE && !vcc_on) ||
                           (mode_q == pwr_ctl_pkg::ST_RESTART && vcc_off); // R6 R18
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clamp_release_o <= 1'b0;
      auto_restart_o  <= 1'b0;
      soft_start_o    <= 1'b0;
    end else begin
      clamp_release_o <= prot_done; // R13
      auto_restart_o  <= (mode_q == pwr_ctl_pkg::ST_RESTART) ||
                         (mode_q == pwr_ctl_pkg::ST_CHARGE && count_q != '0);
      soft_start_o    <= (mode_q == pwr_ctl_pkg::ST_SOFT); // R20
    end
  end

  // ********************************
  // register file
  // ********************************
  logic req;
  logic hit_ctrl;
  logic hit_count;
  assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign hit_ctrl  = wb_adr_i == pwr_ctl_pkg::CTRL_OFS;
  assign hit_count = wb_adr_i == pwr_ctl_pkg::COUNT_OFS;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= pwr_ctl_pkg::CTRL_RST;
    end else if (req && wb_we_i && hit_ctrl && wb_sel_i[0]) begin
      ctrl_q <= wb_dat_i[1:0];
    end
  end

  logic restart_entry;
  assign restart_entry = (mode_q == pwr_ctl_pkg::ST_NORMAL && (hard_fault || spike_done)) ||
                         (mode_q == pwr_ctl_pkg::ST_BURST && hard_fault) ||
                         (mode_q == pwr_ctl_pkg::ST_SOFT &&
                          (hard_fault || (soft_done && fb_over)));
  // restart entries; a new entry beats a clearing write in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_q <= '0;
    end else if (mode_q != pwr_ctl_pkg::ST_RESTART && restart_entry) begin
      count_q <= (count_q == '1) ? count_q : count_q + 1'b1;
    end else if (req && wb_we_i && hit_count && wb_sel_i[0]) begin
      count_q <= '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        pwr_ctl_pkg::CTRL_OFS:   wb_dat_o <= {30'h0, ctrl_q};
        pwr_ctl_pkg::STATUS_OFS: wb_dat_o <= {15'h0, hard_fault, fb_over,
                                   fb_low, 2'h0, soft_start_o, auto_restart_o,
                                   startup_cell_en_o, clamp_release_o,
                                   reduced_limit_o, bias_en_o, burst_flag_o,
                                   1'b0, 4'(mode_q)};
        pwr_ctl_pkg::COUNT_OFS:  wb_dat_o <= {16'h0, count_q};
        default:                 wb_dat_o <= 32'h0;
      endcase
    end
  end

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  burst_entry_timed_a: assert property ( // R4
    $rose(burst_flag_o) |-> $past(burst_done, 2) && $past(fb_low, 2))
    else $error("burst entered without full blanking");
  burst_bias_off_a: assert property ( // R5
    $rose(burst_flag_o) |-> !bias_en_o)
    else $error("bias still on at burst entry");
  burst_cell_off_a: assert property ( // R6
    burst_flag_o |-> !startup_cell_en_o)
    else $error("startup cell on in burst");
  burst_wake_bias_a: assert property ( // R7
    mode_q == pwr_ctl_pkg::ST_BURST && !bias_en_o && fb_wake && !hard_fault
    |=> bias_en_o)
    else $error("bias not resumed on wake");
  burst_sleep_bias_a: assert property ( // R9
    mode_q == pwr_ctl_pkg::ST_BURST && bias_en_o && fb_sleep && !fb_over && !hard_fault
    |=> !bias_en_o)
    else $error("bias not dropped on sleep");
  reduced_limit_tie_a: assert property ( // R8
    reduced_limit_o == burst_flag_o)
    else $error("current limit select differs from burst flag");
  burst_exit_a: assert property ( // R10
    mode_q == pwr_ctl_pkg::ST_BURST && fb_over && !hard_fault
    |=> mode_q == pwr_ctl_pkg::ST_NORMAL ##1 !reduced_limit_o)
    else $error("burst not left on overload");
  clamp_follows_a: assert property ( // R13
    $rose(clamp_release_o) |-> $past(prot_run) && $past(fb_over))
    else $error("clamp released without overload blanking");
  burst_cnt_clear_a: assert property ( // R2
    !fb_low |=> !burst_done)
    else $error("burst counter not cleared");
  hard_fault_fast_a: assert property ( // R17
    mode_q == pwr_ctl_pkg::ST_NORMAL && hard_fault |=> mode_q == pwr_ctl_pkg::ST_RESTART)
    else $error("hard fault did not restart at once");
  restart_cell_a: assert property ( // R18
    mode_q == pwr_ctl_pkg::ST_RESTART && vcc_off |=> startup_cell_en_o ##1
    mode_q == pwr_ctl_pkg::ST_CHARGE)
    else $error("startup cell not enabled at turn-off");
  spike_gate_a: assert property ( // R15
    spike_done |-> clamp_release_o && prot_done)
    else $error("restart before both blanking conditions");

  burst_seen_c:   cover property ($rose(burst_flag_o));
  burst_cycle_c:  cover property (burst_flag_o && $fell(bias_en_o) ##[1:200] $rose(bias_en_o));
  restart_ovl_c:  cover property ($rose(clamp_release_o) ##[1:1000] $rose(auto_restart_o));
  restart_loop_c: cover property ($fell(startup_cell_en_o) ##1 soft_start_o);
endmodule // pwr_ctl

// file: core/pwr_ctl_pkg.sv
// constants for the burst and auto-restart control unit
package pwr_ctl_pkg;
  // ********************************
  // clock and intervals
  // ********************************
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned BLANK_MS    = 20;
  localparam int unsigned SOFT_MS     = 20;
  localparam int unsigned SPIKE_US    = 30;
  localparam int unsigned BLANK_CYC   = 32'((64'(BLANK_MS) * 64'(CLK_HZ)) / 64'd1000);
  localparam int unsigned SOFT_CYC    = 32'((64'(SOFT_MS) * 64'(CLK_HZ)) / 64'd1000);
  localparam int unsigned SPIKE_CYC   = 32'((64'(SPIKE_US) * 64'(CLK_HZ)) / 64'd1000000);
  localparam int unsigned TMR_W       = 32;
  // ********************************
  // register map
  // ********************************
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  STATUS_OFS  = 8'h04;
  localparam logic [7:0]  COUNT_OFS   = 8'h08;
  localparam int unsigned CTRL_EXT    = 0;
  localparam int unsigned CTRL_SWF    = 1;
  localparam logic [1:0]  CTRL_RST    = 2'h1;
  localparam int unsigned ST_STATE    = 0;
  localparam int unsigned ST_FLAGS    = 4;
  localparam int unsigned ST_FAULT    = 12;
  localparam int unsigned CNT_W       = 16;
  // ********************************
  // inputs and states
  // ********************************
  localparam int unsigned N_IN        = 12;
  typedef enum logic [2:0] {
    ST_CHARGE, ST_SOFT, ST_NORMAL, ST_BURST, ST_RESTART
  } mode_t;
endpackage

// file: core/sync_bank.sv
// two-flop synchroniser bank for comparator and fault inputs
`timescale 1ns/1ps
module sync_bank #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  // ********************************
  // one stage pair per bit
  // ********************************
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        meta_q[i] <= 1'b0;
        sync_o[i] <= 1'b0;
      end else begin
        meta_q[i] <= async_i[i];
        sync_o[i] <= meta_q[i];
      end
    end
  end
endmodule // sync_bank

// file: core/interval_timer.sv
// saturating interval counter, cleared whenever its run condition drops
`timescale 1ns/1ps
module interval_timer #(
  parameter int unsigned LIMIT = 1
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic run_i,
  output logic      done_o
);
  logic [pwr_ctl_pkg::TMR_W-1:0] cnt_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (!run_i) begin
      cnt_q <= '0;
    end else if (cnt_q != LIMIT) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // done stands from LIMIT edges after run rose until run drops
  assign done_o = run_i && (cnt_q == LIMIT);
endmodule // interval_timer

// file: test/cmp_front.sv
// comparator front end model: feedback, supply and blanking pin thresholds
`timescale 1ns/1ps
module cmp_front #(
  parameter int unsigned VOFF_MV = 10500,
  parameter int unsigned VON_MV  = 16000,
  parameter int unsigned STEP_MV = 100
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // analogue levels in millivolts
  input  wire logic [15:0] fb_mv_i,
  input  wire logic [15:0] vcc_mv_i,
  input  wire logic        clamp_release_i,
  // comparator outputs
  output logic             entry_o,
  output logic             wake_o,
  output logic             sleep_o,
  output logic             over_o,
  output logic             pin_o,
  output logic             off_o,
  output logic             on_o
);
  // ********************************
  // thresholds
  // ********************************
  logic [15:0] pin_mv_q;
  assign entry_o = fb_mv_i < 16'h0546;
  assign wake_o  = fb_mv_i > 16'h0DAC;
  assign sleep_o = fb_mv_i <= 16'h0BB8;
  assign over_o  = fb_mv_i > 16'h0FA0;
  assign pin_o   = pin_mv_q >= 16'h0FA0;
  assign off_o   = vcc_mv_i <= 16'(VOFF_MV);
  assign on_o    = vcc_mv_i >= 16'(VON_MV);
  // ********************************
  // blanking pin capacitor
  // ********************************
  // ramp stands for the external capacitor, so the pin lags the release
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_mv_q <= 16'h0384;
    end else if (!clamp_release_i) begin
      pin_mv_q <= 16'h0384;
    end else if (pin_mv_q < 16'h0FA0) begin
      pin_mv_q <= pin_mv_q + 16'(STEP_MV);
    end
  end
endmodule // cmp_front

// file: test/tb.sv
// self-checking bench for the burst and auto-restart control unit
`timescale 1ns/1ps
module tb;
  // ********************************
  // signals
  // ********************************
  localparam int unsigned BC = 40;
  localparam int unsigned SC = 40;
  localparam int unsigned PC = 6;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [15:0] fb_mv = 16'h07D0;
  logic [15:0] vcc_mv = 16'h1388;
  logic [4:0]  flt = 5'h00;
  logic        ent, wak, slp, ovl, pin, voff, von;
  logic        burst_flag_o, bias_en_o, reduced_limit_o, clamp_release_o;
  logic        startup_cell_en_o, auto_restart_o, soft_start_o;
  logic [6:0]  obs;
  logic [13:0] note;
  logic [31:0] rd_q[$];
  logic [13:0] out_q[$];
  int          err_total = 0;
  int          cmp_count = 0;
  assign obs = {burst_flag_o, bias_en_o, reduced_limit_o, clamp_release_o,
                startup_cell_en_o, auto_restart_o, soft_start_o};
  always #2.5 clk_i = ~clk_i;
  pwr_ctl #(.BLANK_CYC(BC), .SOFT_CYC(SC), .SPIKE_CYC(PC)) pwr_ctl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .burst_entry_comparator_i(ent),
    .burst_wake_comparator_i(wak), .burst_sleep_comparator_i(slp),
    .overload_comparator_i(ovl), .blanking_pin_comparator_i(pin),
    .vcc_off_cmp_i(voff), .vcc_on_cmp_i(von), .vcc_ovp_i(flt[0]),
    .over_temp_i(flt[1]), .vcc_uvlo_i(flt[2]), .opto_short_i(flt[3]),
    .ext_restart_i(flt[4]), .burst_flag_o(burst_flag_o), .bias_en_o(bias_en_o),
    .reduced_limit_o(reduced_limit_o), .clamp_release_o(clamp_release_o),
    .startup_cell_en_o(startup_cell_en_o), .auto_restart_o(auto_restart_o),
    .soft_start_o(soft_start_o));
  cmp_front cmp_front_inst (
    .clk_i(clk_i), .rst_i(rst_i), .fb_mv_i(fb_mv), .vcc_mv_i(vcc_mv),
    .clamp_release_i(clamp_release_o), .entry_o(ent), .wake_o(wak), .sleep_o(slp),
    .over_o(ovl), .pin_o(pin), .off_o(voff), .on_o(von));
  // ********************************
  // checking and reporting
  // ********************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // watcher: read data at the edge that samples ack, output notes once per cycle
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0) begin
      chk(wb_dat_o, rd_q.pop_front());
    end
  end
  always @(negedge clk_i) begin
    if (out_q.size() > 0) begin
      note = out_q.pop_front();
      chk({25'h0, obs & note[13:7]}, {25'h0, note[6:0]});
    end
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    wrap_up();
  end
  // ********************************
  // driver tasks
  // ********************************
  task automatic wb_go(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      wrap_up();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wb_rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb_go(1'b0, a, 32'h0);
  endtask
  // outputs must hold the masked value for n cycles
  task automatic hold_chk(input logic [6:0] m, input logic [6:0] e, input int n);
    repeat (n) begin
      out_q.push_back({m, e});
      @(posedge clk_i);
    end
  endtask
  // outputs must reach the masked value within max cycles
  task automatic settle(input logic [6:0] m, input logic [6:0] e, input int max);
    int i;
    i = 0;
    do begin
      @(negedge clk_i);
      i++;
    end while ((obs & m) !== e && i < max);
    if ((obs & m) !== e) begin
      err_total++;
      wrap_up();
    end
    @(posedge clk_i);
    out_q.push_back({m, e});
  endtask
  function automatic logic [15:0] rnd(input int unsigned lo, input int unsigned hi);
    return 16'($urandom_range(hi, lo));
  endfunction
  // supply falls to turn-off, recharges to turn-on, then soft start runs
  task automatic restart_cycle();
    vcc_mv <= 16'h2328;
    settle(7'h04, 7'h04, 10);
    vcc_mv <= 16'h4650;
    settle(7'h05, 7'h01, 10);
    hold_chk(7'h01, 7'h01, SC - 8);
  endtask
  // ********************************
  // main sequence
  // ********************************
  initial begin
    void'($urandom(32'h0BFAFFE1));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    hold_chk(7'h7F, 7'h04, 2);
    wb_rd(8'h08, 32'h0);
    wb_rd(8'h0C, 32'h0);
    restart_cycle();
    settle(7'h7F, 7'h20, 16);
    wb_rd(8'h04, 32'h42);
    fb_mv <= rnd(200, 1349);
    hold_chk(7'h40, 7'h00, BC / 2);
    fb_mv <= rnd(1400, 2900);
    hold_chk(7'h7F, 7'h20, 4);
    fb_mv <= rnd(200, 1349);
    hold_chk(7'h40, 7'h00, BC - 2);
    settle(7'h7F, 7'h50, 12);
    fb_mv <= rnd(3501, 3990);
    settle(7'h7F, 7'h70, 8);
    fb_mv <= rnd(2500, 3000);
    settle(7'h7F, 7'h50, 8);
    fb_mv <= rnd(4001, 4900);
    hold_chk(7'h08, 7'h00, BC - 2);
    settle(7'h7F, 7'h28, 16);
    hold_chk(7'h02, 7'h00, 20);
    settle(7'h63, 7'h02, 40);
    restart_cycle();
    settle(7'h22, 7'h02, 20);
    fb_mv <= 16'h07D0;
    restart_cycle();
    settle(7'h7F, 7'h20, 20);
    for (int k = 0; k < 6; k++) begin
      if (k < 5) begin
        flt <= 5'(1 << k);
      end else begin
        wb_go(1'b1, 8'h00, 32'h3);
      end
      settle(7'h22, 7'h02, 8);
      flt <= 5'h00;
      if (k == 5) begin
        wb_go(1'b1, 8'h00, 32'h1);
      end
      restart_cycle();
      settle(7'h7F, 7'h20, 20);
    end
    // basic blanking: pin ignored, restart follows the spike interval only
    wb_go(1'b1, 8'h00, 32'h0);
    fb_mv <= rnd(4001, 4900);
    hold_chk(7'h02, 7'h00, BC - 2);
    settle(7'h63, 7'h02, 16);
    fb_mv <= 16'h07D0;
    wb_go(1'b1, 8'h00, 32'h1);
    restart_cycle();
    settle(7'h7F, 7'h20, 20);
    wb_rd(8'h08, 32'h9);
    wb_go(1'b1, 8'h08, 32'h0);
    wb_rd(8'h08, 32'h0);
    wb_go(1'b1, 8'h0C, 32'hFFFF);
    wb_rd(8'h0C, 32'h0);
    wb_rd(8'h00, 32'h1);
    repeat (3) @(posedge clk_i);
    wrap_up();
  end
endmodule // tb
